// ### capture_compare_unit.sv
`timescale 1ns/10ps
module capture_compare_unit
    import capture_compare_unit_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [NCH-1:0] pin_in,
    output logic [NCH-1:0] pin_out,
    output logic [NCH-1:0] pin_oe,
    input wire logic [1:0] ext_count_in,
    input wire logic general_upper_timer_ovf,
    output logic irq
);

    // Elaboration check on channel count
    if (NCH != CHANNELS || NCH % 2 != 0) begin : g_bad_nch
        $error("channel count must be sixteen");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    reg_req_t req;
    assign req.addr = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr = reg_wr;
    assign req.rd = reg_rd;

    logic [15:0] tctrl_r [2];
    logic [15:0] gctrl_r;
    logic [NCH-1:0] stat_r;
    logic [NCH-1:0] mask_r;
    logic [15:0] cc_r [NCH];
    cc_mode_t mode_r [NCH];
    logic [NCH-1:0] pair_r;
    logic [NCH-1:0] cap_ev;
    logic [NCH-1:0] cmp_irq;
    logic [NCH-1:0] pin_r;
    logic [NCH-1:0] pin_d_r;
    logic [15:0] tb_rel [2];
    tbase_t tb [2];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tctrl_r[0] <= RESET_WORD;
            tctrl_r[1] <= RESET_WORD;
            gctrl_r <= RESET_WORD;
            mask_r <= '0;
        end else if (req.wr) begin
            case (req.addr)
                OFS_T0_CTRL: tctrl_r[0] <= req.wdata;
                OFS_T1_CTRL: tctrl_r[1] <= req.wdata;
                OFS_GCTRL: gctrl_r <= req.wdata;
                OFS_IRQ_MASK: mask_r <= req.wdata[NCH-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time bases

    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tb
            time_base #(.W(TIMER_W)) u_tb (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .run(tctrl_r[t][TC_RUN]),
                .src(tctrl_r[t][TC_SRC_LO +: TC_SRC_W]),
                .stagger(gctrl_r[GC_STAGGER]),
                .ext_in(ext_count_in[t]),
                .gen_ovf(general_upper_timer_ovf),
                .wr_val(req.wr &&
                    req.addr == (t == 0 ? OFS_T0_VAL : OFS_T1_VAL)),
                .wr_rel(req.wr &&
                    req.addr == (t == 0 ? OFS_T0_REL : OFS_T1_REL)),
                .wdata(req.wdata),
                .tb(tb[t]),
                .reload_r(tb_rel[t])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Channels

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            tbase_t my_tb;
            logic is_cap;
            logic rise;
            logic fall;
            logic trig;
            logic match;
            logic hit_r;
            logic done_r;
            logic act;
            logic wr_cc;
            logic wr_md;
            // Upper channel of a pair drives the lower channel's pin
            localparam int PIN = (c % 2 == 1) ? c - 1 : c;

            assign my_tb = mode_r[c].tsel ? tb[1] : tb[0];
            assign is_cap = mode_r[c].func inside
                {FN_CAP_RISE, FN_CAP_FALL, FN_CAP_BOTH};
            assign rise = pin_in[c] & ~pin_d_r[c];
            assign fall = ~pin_in[c] & pin_d_r[c];
            always_comb begin
                case (mode_r[c].func)
                    FN_CAP_RISE: trig = rise;
                    FN_CAP_FALL: trig = fall;
                    FN_CAP_BOTH: trig = rise | fall;
                    default: trig = 1'b0;
                endcase
            end
            assign cap_ev[c] = trig;
            assign match = !is_cap && mode_r[c].func != FN_OFF &&
                my_tb.step && my_tb.value == cc_r[c];
            // Mode 2 and 3 allow one event per period
            assign act = match && !done_r &&
                !((mode_r[c].func == FN_CMP2 ||
                   mode_r[c].func == FN_CMP3) && hit_r);
            assign cmp_irq[c] = act;
            assign wr_cc = req.wr && req.addr == OFS_CC_BASE + 8'(c);
            assign wr_md = req.wr && req.addr == OFS_MODE_BASE + 8'(c);

            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    cc_r[c] <= RESET_WORD;
                end else if (trig) begin
                    cc_r[c] <= my_tb.value;
                end else if (wr_cc) begin
                    cc_r[c] <= req.wdata;
                end
            end

            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    mode_r[c] <= cc_mode_t'(5'h00);
                    pair_r[c] <= 1'b0;
                end else if (wr_md) begin
                    mode_r[c] <= cc_mode_t'(req.wdata[4:0]);
                    pair_r[c] <= req.wdata[8];
                end
            end

            // Period and one-shot tracking
            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    hit_r <= 1'b0;
                    done_r <= 1'b0;
                end else if (wr_md) begin
                    hit_r <= 1'b0;
                    done_r <= 1'b0;
                end else begin
                    if (my_tb.ovf) begin
                        hit_r <= 1'b0;
                    end else if (act) begin
                        hit_r <= 1'b1;
                    end
                    if (act && mode_r[c].oneshot) begin
                        done_r <= 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    pin_d_r[c] <= 1'b0;
                end else begin
                    pin_d_r[c] <= pin_in[c];
                end
            end

            if (c % 2 == 0) begin : g_pin
                logic tog_hi;
                assign tog_hi = pair_r[c] && g_ch[c+1].act;
                always_ff @(posedge ref_clk or posedge sys_rst) begin
                    if (sys_rst) begin
                        pin_r[c] <= 1'b0;
                    end else if (mode_r[c].func == FN_CMP3) begin
                        if (act) begin
                            pin_r[c] <= 1'b1;
                        end else if (my_tb.ovf) begin
                            pin_r[c] <= 1'b0;
                        end
                    end else if ((mode_r[c].func == FN_CMP1 && act) ^
                                 tog_hi) begin
                        pin_r[c] <= ~pin_r[c];
                    end
                end
                assign pin_oe[c] = !is_cap && (mode_r[c].func == FN_CMP1 ||
                    mode_r[c].func == FN_CMP3 || pair_r[c]);
            end else begin : g_pin
                always_ff @(posedge ref_clk or posedge sys_rst) begin
                    if (sys_rst) begin
                        pin_r[c] <= 1'b0;
                    end else if (mode_r[c].func == FN_CMP3) begin
                        if (act) begin
                            pin_r[c] <= 1'b1;
                        end else if (my_tb.ovf) begin
                            pin_r[c] <= 1'b0;
                        end
                    end else if (mode_r[c].func == FN_CMP1 && act &&
                                 !pair_r[PIN]) begin
                        pin_r[c] <= ~pin_r[c];
                    end
                end
                assign pin_oe[c] = !is_cap && !pair_r[PIN] &&
                    (mode_r[c].func == FN_CMP1 ||
                     mode_r[c].func == FN_CMP3);
            end
        end
    endgenerate

    assign pin_out = pin_r;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: set beats write-one clear

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_r <= '0;
        end else begin
            stat_r <= (stat_r & ~((req.wr && req.addr == OFS_IRQ_STAT) ?
                req.wdata[NCH-1:0] : '0)) | cap_ev | cmp_irq;
        end
    end

    assign irq = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (req.rd) begin
            reg_rdata <= 16'h0000;
            if (req.addr >= OFS_CC_BASE && req.addr < OFS_CC_BASE + 8'(NCH))
            begin
                reg_rdata <= cc_r[4'(req.addr - OFS_CC_BASE)];
            end else if (req.addr >= OFS_MODE_BASE &&
                         req.addr < OFS_MODE_BASE + 8'(NCH)) begin
                reg_rdata <= {7'h00,
                    pair_r[4'(req.addr - OFS_MODE_BASE)], 3'h0,
                    mode_r[4'(req.addr - OFS_MODE_BASE)]};
            end else begin
                case (req.addr)
                    OFS_T0_VAL: reg_rdata <= tb[0].value;
                    OFS_T0_REL: reg_rdata <= tb_rel[0];
                    OFS_T1_VAL: reg_rdata <= tb[1].value;
                    OFS_T1_REL: reg_rdata <= tb_rel[1];
                    OFS_T0_CTRL: reg_rdata <= tctrl_r[0];
                    OFS_T1_CTRL: reg_rdata <= tctrl_r[1];
                    OFS_GCTRL: reg_rdata <= gctrl_r;
                    OFS_IRQ_STAT: reg_rdata <= stat_r;
                    OFS_IRQ_MASK: reg_rdata <= mask_r;
                    OFS_PIN_STATE: reg_rdata <= pin_r;
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule : capture_compare_unit

// ### capture_compare_unit_pkg.sv
package capture_compare_unit_pkg;

    localparam int CHANNELS = 16;
    localparam int TIMER_W = 16;
    localparam int STAGGER_DIV = 8;

    // Register offsets
    localparam logic [7:0] OFS_T0_VAL = 8'h00;
    localparam logic [7:0] OFS_T0_REL = 8'h01;
    localparam logic [7:0] OFS_T1_VAL = 8'h02;
    localparam logic [7:0] OFS_T1_REL = 8'h03;
    localparam logic [7:0] OFS_T0_CTRL = 8'h04;
    localparam logic [7:0] OFS_T1_CTRL = 8'h05;
    localparam logic [7:0] OFS_GCTRL = 8'h06;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h07;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0] OFS_PIN_STATE = 8'h09;
    localparam logic [7:0] OFS_CC_BASE = 8'h10;
    localparam logic [7:0] OFS_MODE_BASE = 8'h20;

    // Timer control fields
    localparam int TC_RUN = 0;
    localparam int TC_SRC_LO = 1;
    localparam int TC_SRC_W = 3;
    // Global control fields
    localparam int GC_STAGGER = 0;

    // Channel mode fields
    localparam int MD_FUNC_LO = 0;
    localparam int MD_FUNC_W = 3;
    localparam int MD_TSEL = 3;
    localparam int MD_ONESHOT = 4;

    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Time base clock source selection
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV2 = 3'h1;
    localparam logic [2:0] SRC_DIV4 = 3'h2;
    localparam logic [2:0] SRC_DIV8 = 3'h3;
    localparam logic [2:0] SRC_DIV16 = 3'h4;
    localparam logic [2:0] SRC_EXT_RISE = 3'h5;
    localparam logic [2:0] SRC_GEN_OVF = 3'h6;

    // Channel function
    typedef enum logic [2:0] {
        FN_OFF = 3'h0,
        FN_CAP_RISE = 3'h1,
        FN_CAP_FALL = 3'h2,
        FN_CAP_BOTH = 3'h3,
        FN_CMP0 = 3'h4,
        FN_CMP1 = 3'h5,
        FN_CMP2 = 3'h6,
        FN_CMP3 = 3'h7
    } cc_func_t;

    typedef struct packed {
        logic oneshot;
        logic tsel;
        cc_func_t func;
    } cc_mode_t;

    typedef struct packed {
        logic [TIMER_W-1:0] value;
        logic step;
        logic ovf;
    } tbase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : capture_compare_unit_pkg

// ### cc_asserts.sv
`timescale 1ns/10ps
module cc_asserts
    import capture_compare_unit_pkg::*;
#(
    parameter int NCH = CHANNELS
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [NCH-1:0] pin_in,
    input wire logic [NCH-1:0] pin_out,
    input wire logic [NCH-1:0] pin_oe,
    input wire logic [1:0] ext_count_in,
    input wire logic general_upper_timer_ovf,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic [15:0] md [NCH];
    logic [15:0] mask_r, exp_r;
    logic exp_v_r;
    logic [1:0] run_r;
    logic [2:0] idle_r;
    logic [NCH-1:0] cap_m, drv_m, odd_m, quiet_m;
    logic md_wr;
    assign md_wr = reg_wr && reg_addr[7:4] == 4'h2;
    ////////////////////////////////////////////////////////////////////////
    // Shadow of mode, mask and run bits
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            md <= '{default: 16'h0000};
            mask_r <= 16'h0000;
            run_r <= 2'h0;
        end else if (reg_wr) begin
            if (md_wr) begin
                md[reg_addr[3:0]] <= reg_wdata & 16'h011F;
            end
            if (reg_addr == OFS_IRQ_MASK) begin
                mask_r <= reg_wdata;
            end
            if (reg_addr == OFS_T0_CTRL || reg_addr == OFS_T1_CTRL) begin
                run_r[reg_addr[0]] <= reg_wdata[TC_RUN];
            end
        end
    end
    // Expected read data and time since timers stopped
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exp_v_r <= 1'b0;
            exp_r <= 16'h0000;
            idle_r <= 3'h0;
        end else begin
            exp_v_r <= reg_rd && (reg_addr[7:4] == 4'h2 ||
                reg_addr == OFS_IRQ_MASK || reg_addr > 8'h2F);
            exp_r <= (reg_addr[7:4] == 4'h2) ? md[reg_addr[3:0]] :
                (reg_addr == OFS_IRQ_MASK) ? mask_r : 16'h0000;
            idle_r <= (reg_wr || |run_r) ? 3'h0 :
                (idle_r == 3'h7) ? idle_r : idle_r + 3'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            odd_m[i] = i[0] && md[i & ~1][8];
            cap_m[i] = md[i][2:0] inside {FN_CAP_RISE, FN_CAP_FALL,
                FN_CAP_BOTH};
            drv_m[i] = md[i][2:0] inside {FN_CMP1, FN_CMP3} && !odd_m[i];
            quiet_m[i] = !(md[i][2:0] inside {FN_CMP1, FN_CMP3}) &&
                !md[i][8] && !odd_m[i];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_oe_capture: assert property ((pin_oe & cap_m) == '0)
        else $error("capture pin driven");
    a_oe_compare: assert property ((pin_oe & drv_m) == drv_m)
        else $error("compare pin not driven");
    a_pair_oe_off: assert property ((pin_oe & odd_m) == '0)
        else $error("paired odd pin driven");
    a_quiet_pins: assert property (!$past(md_wr) && !$past(md_wr, 2) |->
        ((pin_out ^ $past(pin_out)) & quiet_m) == '0)
        else $error("pin moved in interrupt-only mode");
    a_irq_masked: assert property (mask_r == 16'h0000 |-> !irq)
        else $error("irq high with all masked");
    a_cfg_read: assert property (exp_v_r |-> reg_rdata == exp_r)
        else $error("config readback wrong");
    a_pin_state: assert property (reg_rd && reg_addr == OFS_PIN_STATE
        |=> reg_rdata == $past(pin_out))
        else $error("pin state readback wrong");
    a_stalled_quiet: assert property (idle_r == 3'h7
        |-> $stable(pin_out))
        else $error("pin moved with timers stopped");
endmodule : cc_asserts

bind capture_compare_unit cc_asserts #(.NCH(NCH)) cc_asserts_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_count_in(ext_count_in),
    .general_upper_timer_ovf(general_upper_timer_ovf), .irq(irq)
);

// ### pin_model.sv
`timescale 1ns/10ps
module pin_model #(
    parameter int NCH = 16
) (
    input wire logic [NCH-1:0] pin_out,
    input wire logic [NCH-1:0] pin_oe,
    input wire logic [NCH-1:0] drive_lvl,
    output logic [NCH-1:0] pin_in
);
    // Device wins where it drives, else the external source
    assign pin_in = (pin_out & pin_oe) | (drive_lvl & ~pin_oe);
endmodule : pin_model

// ### tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    n_mismatch++; $display("unexpected at %0t: got %h want %h", \
    $time, (a), (b)); end end
module tb
    import capture_compare_unit_pkg::*;
;
    localparam logic [15:0] MDV [8] = '{16'h0004, 16'h0006, 16'h0005,
        16'h0007, 16'h0015, 16'h0000, 16'h0105, 16'h0005};
    localparam logic [15:0] CCV [8] = '{16'hFFE8, 16'hFFE8, 16'hFFE8,
        16'hFFE8, 16'hFFE8, 16'hFFE8, 16'hFFE4, 16'hFFEC};
    localparam logic [7:0] RST_A [11] = '{OFS_T0_REL, OFS_T1_REL,
        OFS_T0_CTRL, OFS_GCTRL, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_PIN_STATE,
        OFS_CC_BASE, OFS_MODE_BASE, 8'h0C, 8'h40};
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, v0, pin_in, pin_out, pin_oe;
    logic [15:0] drive_lvl = 16'h0000;
    logic [1:0] ext_count_in = 2'h0;
    logic general_upper_timer_ovf = 1'b0;
    logic irq;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #5 ref_clk = ~ref_clk;
    capture_compare_unit capture_compare_unit_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_count_in(ext_count_in),
        .general_upper_timer_ovf(general_upper_timer_ovf), .irq(irq));
    pin_model pin_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
        .drive_lvl(drive_lvl), .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge ref_clk);
    endtask : rd
    // Wait until pin k is low, or until irq is high when k is 16
    task automatic wait_ev(input int k);
        int n;
        n = 0;
        while ((k < 16 ? pin_out[k] !== 1'b0 : irq !== 1'b1) && n < 900) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 900) begin
            n_mismatch++;
            $display("unexpected at %0t: wait timed out", $time);
            end_of_test();
        end
    endtask : wait_ev
    // Counts seen by timer t over a 64 cycle window or five pulses
    task automatic rate(input int t, input logic [2:0] s, input logic stg,
        input logic [15:0] n);
        logic [15:0] a, b;
        wr(OFS_GCTRL, {15'h0000, stg});
        wr(OFS_T0_CTRL + 8'(t), {12'h000, s, 1'b1});
        rd(OFS_T0_VAL + 8'(2 * t), a);
        if (s < SRC_EXT_RISE) begin
            repeat (62) @(posedge ref_clk);
        end else begin
            repeat (5) begin
                ext_count_in[t] <= (s == SRC_EXT_RISE);
                general_upper_timer_ovf <= (s == SRC_GEN_OVF);
                @(posedge ref_clk);
                ext_count_in[t] <= 1'b0;
                general_upper_timer_ovf <= 1'b0;
                repeat (4) @(posedge ref_clk);
            end
        end
        rd(OFS_T0_VAL + 8'(2 * t), b);
        `CHK(b - a, n)
        wr(OFS_T0_CTRL + 8'(t), 16'h0000);
    endtask : rate
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        wr(8'h0C, 16'hFFFF);
        wr(OFS_PIN_STATE, 16'hFFFF);
        foreach (RST_A[i]) begin
            rd(RST_A[i], v0);
            `CHK(v0, RESET_WORD)
        end
        for (int s = 0; s < 5; s++) begin
            rate(0, 3'(s), 1'b0, 16'(64 >> s));
        end
        rate(0, SRC_DIV1, 1'b1, 16'h0008);
        rate(1, SRC_EXT_RISE, 1'b0, 16'h0005);
        rate(1, SRC_GEN_OVF, 1'b0, 16'h0005);
        // Compare modes on a 32 step period
        wr(OFS_T0_REL, 16'hFFE0);
        wr(OFS_T0_VAL, 16'hFFE0);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CC_BASE + 8'(c), CCV[c]);
            wr(OFS_MODE_BASE + 8'(c), MDV[c]);
        end
        rd(OFS_MODE_BASE + 8'h06, v0);
        `CHK(v0, 16'h0105)
        wr(OFS_IRQ_MASK, 16'h0003);
        wr(OFS_T0_CTRL, {12'h000, SRC_DIV16, 1'b1});
        wait_ev(16);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0003, 16'h0003)
        rd(OFS_PIN_STATE, v0);
        `CHK(v0 & 16'h007F, 16'h005C)
        `CHK(pin_oe[6], 1'b1)
        wr(OFS_IRQ_STAT, 16'h0003);
        wr(OFS_CC_BASE, 16'hFFF0);
        wr(OFS_CC_BASE + 8'h01, 16'hFFF0);
        wait_ev(16);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0003, 16'h0001)
        rd(OFS_PIN_STATE, v0);
        `CHK(v0 & 16'h007F, 16'h001C)
        wr(OFS_IRQ_STAT, 16'h0003);
        wait_ev(3);
        wait_ev(16);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0003, 16'h0003)
        rd(OFS_PIN_STATE, v0);
        `CHK(v0 & 16'h007F, 16'h0018)
        wr(OFS_T0_CTRL, 16'h0000);
        // Capture on timer 1, held still
        wr(OFS_T1_VAL, 16'h5A5A);
        for (int c = 8; c < 11; c++) begin
            wr(OFS_MODE_BASE + 8'(c), 16'h0008 | 16'(c - 7));
        end
        wr(OFS_IRQ_MASK, 16'h0700);
        drive_lvl <= 16'h0700;
        wait_ev(16);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0700, 16'h0500)
        rd(OFS_CC_BASE + 8'h08, v0);
        `CHK(v0, 16'h5A5A)
        rd(OFS_CC_BASE + 8'h09, v0);
        `CHK(v0, 16'h0000)
        rd(OFS_CC_BASE + 8'h0A, v0);
        `CHK(v0, 16'h5A5A)
        wr(OFS_IRQ_STAT, 16'h0700);
        wr(OFS_T1_VAL, 16'h1357);
        drive_lvl <= 16'h0000;
        wait_ev(16);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0700, 16'h0600)
        for (int c = 8; c < 11; c++) begin
            rd(OFS_CC_BASE + 8'(c), v0);
            `CHK(v0, c == 8 ? 16'h5A5A : 16'h1357)
        end
        wr(OFS_IRQ_MASK, 16'h0000);
        rd(OFS_IRQ_STAT, v0);
        `CHK(irq, 1'b0)
        wr(OFS_IRQ_STAT, 16'h0700);
        rd(OFS_IRQ_STAT, v0);
        `CHK(v0 & 16'h0700, 16'h0000)
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(pin_out, 16'h0000)
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rd(OFS_T0_REL, v0);
        `CHK(v0, RESET_WORD)
        end_of_test();
    end
endmodule : tb

// ### time_base.sv
`timescale 1ns/10ps
module time_base
    import capture_compare_unit_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [2:0] src,
    input wire logic stagger,
    input wire logic ext_in,
    input wire logic gen_ovf,
    input wire logic wr_val,
    input wire logic wr_rel,
    input wire logic [W-1:0] wdata,
    output tbase_t tb,
    output logic [W-1:0] reload_r
);

    if (W != TIMER_W) begin : g_bad_w
        $error("time_base width must match package");
    end

    logic [3:0] pre_r;
    logic [2:0] stg_r;
    logic ext_d_r;
    logic tick;
    logic [W-1:0] val_r;
    logic step_r;
    logic ovf_r;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_r <= 4'h0;
            stg_r <= 3'h0;
            ext_d_r <= 1'b0;
        end else begin
            pre_r <= pre_r + 4'h1;
            stg_r <= stg_r + 3'h1;
            ext_d_r <= ext_in;
        end
    end

    // Count tick per selected source
    always_comb begin
        case (src)
            SRC_DIV1: tick = 1'b1;
            SRC_DIV2: tick = (pre_r[0] == 1'b1);
            SRC_DIV4: tick = (pre_r[1:0] == 2'h3);
            SRC_DIV8: tick = (pre_r[2:0] == 3'h7);
            SRC_DIV16: tick = (pre_r == 4'hF);
            SRC_EXT_RISE: tick = ext_in & ~ext_d_r;
            SRC_GEN_OVF: tick = gen_ovf;
            default: tick = 1'b0;
        endcase
        if (stagger && src != SRC_EXT_RISE && src != SRC_GEN_OVF) begin
            tick = tick & (stg_r == 3'h7);
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            val_r <= '0;
            step_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            step_r <= 1'b0;
            ovf_r <= 1'b0;
            if (wr_val) begin
                val_r <= wdata;
            end else if (run && tick) begin
                step_r <= 1'b1;
                if (val_r == '1) begin
                    val_r <= reload_r;
                    ovf_r <= 1'b1;
                end else begin
                    val_r <= val_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reload_r <= '0;
        end else if (wr_rel) begin
            reload_r <= wdata;
        end
    end

    assign tb.value = val_r;
    assign tb.step = step_r;
    assign tb.ovf = ovf_r;

endmodule : time_base
